//--- logic/bci_pkg.sv
package bci_pkg;

    // Host register port request, one cycle per access
    typedef struct packed {
        logic       rd;
        logic       wr;
        logic [7:0] addr;
        logic [7:0] wdata;
    } bci_hreq_t;

    // One transmit line bit with its framing context
    typedef struct packed {
        logic       fbit;
        logic [4:0] chan;
        logic       data;
    } bci_txw_t;

    // Register addresses
    localparam logic [7:0] BIT_TOTAL_BYTE0   = 8'hE3;
    localparam logic [7:0] BIT_TOTAL_BYTE1   = 8'hE4;
    localparam logic [7:0] BIT_TOTAL_BYTE2   = 8'hE5;
    localparam logic [7:0] BIT_TOTAL_BYTE3   = 8'hE6;
    localparam logic [7:0] ERROR_TOTAL_BYTE0 = 8'hE7;
    localparam logic [7:0] ERROR_TOTAL_BYTE1 = 8'hE8;
    localparam logic [7:0] ERROR_TOTAL_BYTE2 = 8'hE9;
    localparam logic [7:0] INSERT_RATE_CTL   = 8'hEB;
    localparam logic [7:0] INSERT_COUNT_LOW  = 8'hEC;
    localparam logic [7:0] INSERT_COUNT_HIGH = 8'hED;
    localparam logic [7:0] INSERT_REMAIN_LOW = 8'hEE;
    localparam logic [7:0] INSERT_REMAIN_HI  = 8'hEF;

    // Rate control fields
    localparam int         RATE_LSB       = 0;
    localparam int         CONST_BIT      = 4;
    localparam int         LOAD_BIT       = 7;
    localparam logic [7:0] RATE_CTL_WMASK = 8'h9F;
    localparam logic [3:0] RATE_NONE      = 4'h0;
    localparam logic [3:0] RATE_SHIFT_ADD = 4'h3;

    // Widths and reset values
    localparam int          BIT_TOTAL_W  = 32;
    localparam int          ERR_TOTAL_W  = 24;
    localparam int          INS_COUNT_W  = 10;
    localparam int          INS_PERIOD_W = 18;
    localparam int          CHANNELS     = 24;
    localparam logic [7:0]  REG_RESET    = 8'h00;
    localparam logic [7:0]  UNMAPPED_RD  = 8'h00;
    localparam int          BUF_DEPTH    = 2;

endpackage

//--- logic/bci_sat_cnt.sv
`timescale 1ns/1ps
// Saturating event counter with clear and overflow pulse
module bci_sat_cnt #(
    parameter int W = 32
) (
    input  wire logic         clk,
    input  wire logic         nrst,
    input  wire logic         clr,
    input  wire logic         inc,
    output logic [W-1:0]      value,
    output logic              ovf_evt
);
    import bci_pkg::*;

    typedef struct packed {
        logic [W-1:0] cnt;
        logic         ovf;
    } bci_cnt_st_t;

    bci_cnt_st_t st_r;
    bci_cnt_st_t st_nxt;

    // Hold at all ones rather than wrap; pulse once on reaching it
    always_comb
    begin
        st_nxt     = st_r;
        st_nxt.ovf = 1'b0;
        if (clr)
            st_nxt.cnt = '0;
        else if (inc && !(&st_r.cnt))
        begin
            st_nxt.cnt = st_r.cnt + W'(1);
            st_nxt.ovf = &st_nxt.cnt;
        end
    end

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            st_r <= '0;
        else
            st_r <= st_nxt;
    end

    assign value   = st_r.cnt;
    assign ovf_evt = st_r.ovf;
endmodule

//--- logic/bci_buf2.sv
`timescale 1ns/1ps
// Two-entry buffer; a stalled receiver loses no word
module bci_buf2 (
    input  wire logic              clk,
    input  wire logic              nrst,
    input  wire logic              in_valid,
    output logic                   in_ready,
    input  wire bci_pkg::bci_txw_t in_data,
    output logic                   out_valid,
    input  wire logic              out_ready,
    output bci_pkg::bci_txw_t      out_data
);
    import bci_pkg::*;

    typedef struct packed {
        bci_txw_t [BUF_DEPTH-1:0] mem;
        logic                     wptr;
        logic                     rptr;
        logic [1:0]               cnt;
        logic                     rdy;
        logic                     ov;
        bci_txw_t                 od;
    } bci_buf_st_t;

    bci_buf_st_t st_r;
    bci_buf_st_t st_nxt;
    logic        push;
    logic        pop;

    // Ready kept as a flop so the stall path is registered
    always_comb
    begin
        st_nxt = st_r;
        push   = in_valid && st_r.rdy;
        pop    = out_ready && (st_r.cnt != 2'h0);
        if (push)
        begin
            st_nxt.mem[st_r.wptr] = in_data;
            st_nxt.wptr           = ~st_r.wptr;
        end
        if (pop)
            st_nxt.rptr = ~st_r.rptr;
        st_nxt.cnt = st_r.cnt + {1'b0, push} - {1'b0, pop};
        st_nxt.rdy = (st_nxt.cnt != 2'(BUF_DEPTH));
        // Head word and valid registered so the outputs leave flops
        st_nxt.ov  = (st_nxt.cnt != 2'h0);
        st_nxt.od  = st_nxt.mem[st_nxt.rptr];
    end

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            st_r     <= '0;
            st_r.rdy <= 1'b1;
        end
        else
            st_r <= st_nxt;
    end

    assign in_ready  = st_r.rdy;
    assign out_valid = st_r.ov;
    assign out_data  = st_r.od;
endmodule

//--- logic/bci_top.sv
`timescale 1ns/1ps
module bci_top (
    input  wire logic                clk,
    input  wire logic                nrst,
    input  wire bci_pkg::bci_hreq_t  hreq,
    output logic [7:0]               rdata,
    input  wire logic                rx_bit_en,
    input  wire logic                rx_sync,
    input  wire logic                rx_bit_err,
    input  wire logic                counter_clear_ctl,
    input  wire logic                ovf_flag_clear,
    output logic                     bit_total_overflow,
    output logic                     error_total_overflow,
    input  wire logic                per_chan_mode,
    input  wire logic [23:0]         chan_sel,
    input  wire logic                tx_in_valid,
    output logic                     tx_in_ready,
    input  wire bci_pkg::bci_txw_t   tx_in,
    output logic                     tx_out_valid,
    input  wire logic                tx_out_ready,
    output bci_pkg::bci_txw_t        tx_out
);
    import bci_pkg::*;

    typedef struct packed {
        logic [7:0]              ctl;
        logic [INS_COUNT_W-1:0]  count;
        logic [INS_COUNT_W-1:0]  remain;
        logic [3:0]              rate_act;
        logic [INS_PERIOD_W-1:0] period;
        logic                    load_prev;
        logic                    clr_prev;
        logic [7:0]              rdata;
        logic                    ovf_bit;
        logic                    ovf_err;
    } bci_st_t;

    bci_st_t                 st_r;
    bci_st_t                 st_nxt;
    logic [BIT_TOTAL_W-1:0]  bit_total;
    logic [ERR_TOTAL_W-1:0]  err_total;
    logic                    bit_ovf_evt;
    logic                    err_ovf_evt;
    logic                    clr_pulse;
    logic                    bit_inc;
    logic                    err_inc;
    logic                    buf_in_ready;
    logic                    in_fire;
    logic                    eligible;
    logic                    armed;
    logic                    constant;
    logic                    flip;
    logic                    load_rise;
    logic [CHANNELS-1:0]     chan_hit;
    logic [INS_PERIOD_W-1:0] period_last;
    bci_txw_t                tx_mod;

    // Clear acts on the rising edge of the clear control only
    assign clr_pulse = counter_clear_ctl && !st_r.clr_prev;
    assign bit_inc   = rx_sync && rx_bit_en;
    assign err_inc   = rx_sync && rx_bit_en && rx_bit_err;

    // Received bit and errored bit totals
    bci_sat_cnt #(
        .W       (BIT_TOTAL_W)
    ) u_bit_total (
        .clk     (clk),
        .nrst    (nrst),
        .clr     (clr_pulse),
        .inc     (bit_inc),
        .value   (bit_total),
        .ovf_evt (bit_ovf_evt)
    );

    bci_sat_cnt #(
        .W       (ERR_TOTAL_W)
    ) u_err_total (
        .clk     (clk),
        .nrst    (nrst),
        .clr     (clr_pulse),
        .inc     (err_inc),
        .value   (err_total),
        .ovf_evt (err_ovf_evt)
    );

    // One comparator per time slot; a channel code past the last slot never matches
    for (genvar g = 0; g < CHANNELS; g++)
    begin : g_chan
        assign chan_hit[g] = chan_sel[g] && (tx_in.chan == 5'(g));
    end

    // Insertion decode on the word being accepted this cycle
    assign constant    = st_r.ctl[CONST_BIT];
    assign in_fire     = tx_in_valid && buf_in_ready;
    assign eligible    = in_fire && !tx_in.fbit
                         && (!per_chan_mode || (|chan_hit));
    assign armed       = (st_r.rate_act != RATE_NONE)
                         && (constant || (st_r.remain != '0));
    // Period is 2^(k+3); shift sum kept five bits wide so codes 13 to 15 do not wrap
    assign period_last = INS_PERIOD_W'((19'h1 << ({1'b0, st_r.rate_act} + 5'(RATE_SHIFT_ADD))) - 19'h1);
    assign flip        = eligible && armed && (st_r.period == period_last);
    assign load_rise   = st_r.ctl[LOAD_BIT] && !st_r.load_prev;

    always_comb
    begin
        tx_mod      = tx_in;
        tx_mod.data = tx_in.data ^ flip;
    end

    // Main state update
    always_comb
    begin
        st_nxt           = st_r;
        st_nxt.load_prev = st_r.ctl[LOAD_BIT];
        st_nxt.clr_prev  = counter_clear_ctl;

        // Host writes; unused control bits are forced to zero
        if (hreq.wr)
        begin
            unique case (hreq.addr)
                INSERT_RATE_CTL:   st_nxt.ctl = hreq.wdata & RATE_CTL_WMASK;
                INSERT_COUNT_LOW:  st_nxt.count[7:0] = hreq.wdata;
                INSERT_COUNT_HIGH: st_nxt.count[INS_COUNT_W-1:8] = hreq.wdata[1:0];
                default:           st_nxt.ctl = st_r.ctl;
            endcase
        end

        // Host reads answer one cycle later; unmapped reads give zero
        if (hreq.rd)
        begin
            unique case (hreq.addr)
                BIT_TOTAL_BYTE0:   st_nxt.rdata = bit_total[7:0];
                BIT_TOTAL_BYTE1:   st_nxt.rdata = bit_total[15:8];
                BIT_TOTAL_BYTE2:   st_nxt.rdata = bit_total[23:16];
                BIT_TOTAL_BYTE3:   st_nxt.rdata = bit_total[31:24];
                ERROR_TOTAL_BYTE0: st_nxt.rdata = err_total[7:0];
                ERROR_TOTAL_BYTE1: st_nxt.rdata = err_total[15:8];
                ERROR_TOTAL_BYTE2: st_nxt.rdata = err_total[23:16];
                INSERT_RATE_CTL:   st_nxt.rdata = st_r.ctl;
                INSERT_COUNT_LOW:  st_nxt.rdata = st_r.count[7:0];
                INSERT_COUNT_HIGH: st_nxt.rdata = {6'h00, st_r.count[INS_COUNT_W-1:8]};
                INSERT_REMAIN_LOW: st_nxt.rdata = st_r.remain[7:0];
                INSERT_REMAIN_HI:  st_nxt.rdata = {6'h00, st_r.remain[INS_COUNT_W-1:8]};
                default:           st_nxt.rdata = UNMAPPED_RD;
            endcase
        end

        // Rate only changes at a framing bit; phase restarts with it
        if (in_fire && tx_in.fbit)
        begin
            st_nxt.rate_act = st_r.ctl[RATE_LSB +: 4];
            if (st_nxt.rate_act != st_r.rate_act)
                st_nxt.period = '0;
        end
        else if (eligible && armed)
        begin
            if (flip)
                st_nxt.period = '0;
            else
                st_nxt.period = st_r.period + INS_PERIOD_W'(1);
        end

        // Load wins over a decrement landing in the same cycle
        if (load_rise)
            st_nxt.remain = st_r.count;
        else if (flip && !constant)
            st_nxt.remain = st_r.remain - INS_COUNT_W'(1);

        // Sticky overflow flags; a new overflow beats a clear
        if (ovf_flag_clear)
        begin
            st_nxt.ovf_bit = 1'b0;
            st_nxt.ovf_err = 1'b0;
        end
        if (bit_ovf_evt)
            st_nxt.ovf_bit = 1'b1;
        if (err_ovf_evt)
            st_nxt.ovf_err = 1'b1;
    end

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            st_r       <= '0;
            st_r.ctl   <= REG_RESET;
            st_r.rdata <= REG_RESET;
        end
        else
            st_r <= st_nxt;
    end

    // Output buffer absorbs a receiver stall without dropping a bit
    bci_buf2 u_buf (
        .clk       (clk),
        .nrst      (nrst),
        .in_valid  (tx_in_valid),
        .in_ready  (buf_in_ready),
        .in_data   (tx_mod),
        .out_valid (tx_out_valid),
        .out_ready (tx_out_ready),
        .out_data  (tx_out)
    );

    assign tx_in_ready          = buf_in_ready;
    assign rdata                = st_r.rdata;
    assign bit_total_overflow   = st_r.ovf_bit;
    assign error_total_overflow = st_r.ovf_err;
endmodule

//--- tb/bci_assertions.sv
`timescale 1ns/1ps
module bci_checker (
    input wire logic               clk,
    input wire logic               nrst,
    input wire bci_pkg::bci_hreq_t hreq,
    input wire logic [7:0]         rdata,
    input wire logic               rx_bit_en,
    input wire logic               rx_sync,
    input wire logic               rx_bit_err,
    input wire logic               counter_clear_ctl,
    input wire logic               ovf_flag_clear,
    input wire logic               bit_total_overflow,
    input wire logic               error_total_overflow,
    input wire logic               per_chan_mode,
    input wire logic [23:0]        chan_sel,
    input wire logic               tx_in_valid,
    input wire logic               tx_in_ready,
    input wire bci_pkg::bci_txw_t  tx_in,
    input wire logic               tx_out_valid,
    input wire logic               tx_out_ready,
    input wire bci_pkg::bci_txw_t  tx_out
);
    import bci_pkg::*;
    logic       arm_r;
    logic [7:0] lo_r;
    // Shadow of stored load bit and low count byte
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            arm_r <= 1'b0;
            lo_r  <= 8'h00;
        end
        else if (hreq.wr && hreq.addr == INSERT_RATE_CTL)
            arm_r <= hreq.wdata[LOAD_BIT];
        else if (hreq.wr && hreq.addr == INSERT_COUNT_LOW)
            lo_r <= hreq.wdata;
    end
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!nrst);
    sequence rd_at(logic [7:0] a);
        hreq.rd && !hreq.wr && hreq.addr == a;
    endsequence
    sequence quiet_s;
        !hreq.wr && !tx_in_valid && !tx_out_valid;
    endsequence
    sequence ctl_wr_s;
        hreq.wr && hreq.addr == INSERT_RATE_CTL;
    endsequence
    // Frozen totals need sync low from the first read through the cycle before the second
    sequence still_s;
        !rx_sync && !counter_clear_ctl;
    endsequence
    unmapped_read_a: assert property (hreq.rd && (hreq.addr < BIT_TOTAL_BYTE0 || hreq.addr > INSERT_REMAIN_HI)
        |=> rdata == UNMAPPED_RD) else $error("unmapped read not zero");
    ctl_mask_a: assert property (ctl_wr_s ##1 !hreq.wr ##1 rd_at(INSERT_RATE_CTL)
        |=> rdata == ($past(hreq.wdata, 3) & RATE_CTL_WMASK)) else $error("rate control readback");
    clear_zero_a: assert property ($rose(counter_clear_ctl) && !rx_sync ##1 rd_at(BIT_TOTAL_BYTE0)
        |=> rdata == 8'h00) else $error("bit total not cleared");
    hold_unsync_a: assert property (rd_at(BIT_TOTAL_BYTE0) ##0 still_s ##1 still_s ##1 rd_at(BIT_TOTAL_BYTE0)
        |=> rdata == $past(rdata, 2)) else $error("total moved out of sync");
    bit_step_a: assert property (rd_at(BIT_TOTAL_BYTE0) ##0 (rx_bit_en && rx_sync && !counter_clear_ctl)[*2]
        ##1 rd_at(BIT_TOTAL_BYTE0) |=> rdata == 8'($past(rdata, 2) + 8'h02) || bit_total_overflow)
        else $error("bit total step wrong");
    out_hold_a: assert property (tx_out_valid && !tx_out_ready |=> tx_out_valid && $stable(tx_out))
        else $error("output word dropped");
    pass_through_a: assert property (tx_in_valid && tx_in_ready && !tx_out_valid |=> tx_out_valid
        && tx_out.chan == $past(tx_in.chan) && tx_out.fbit == $past(tx_in.fbit)
        && (!tx_out.fbit || tx_out.data == $past(tx_in.data))) else $error("word passed wrongly");
    count_load_a: assert property (ctl_wr_s ##0 (hreq.wdata[LOAD_BIT] && !arm_r && !tx_in_valid)
        ##1 quiet_s ##1 (rd_at(INSERT_REMAIN_LOW) ##0 quiet_s) |=> rdata == lo_r) else $error("count not loaded");
endmodule
bind bci_top bci_checker u_bci_checker (.clk, .nrst, .hreq, .rdata, .rx_bit_en, .rx_sync, .rx_bit_err,
    .counter_clear_ctl, .ovf_flag_clear, .bit_total_overflow, .error_total_overflow, .per_chan_mode,
    .chan_sel, .tx_in_valid, .tx_in_ready, .tx_in, .tx_out_valid, .tx_out_ready, .tx_out);

//--- tb/bci_line_sink.sv
`timescale 1ns/1ps
// Line-side receiver; words arrive as zero so a one is a flip
module bci_line_sink (
    input wire logic              clk,
    input wire logic              nrst,
    input wire logic              stall,
    input wire logic              slow,
    input wire logic              tx_out_valid,
    input wire bci_pkg::bci_txw_t tx_out,
    output logic                  tx_out_ready,
    output int                    flips,
    output int                    fbit_flips,
    output int                    words
);
    import bci_pkg::*;
    logic phase_r;
    // Ready moves after the edge; slow mode takes every other cycle
    always @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            phase_r <= 1'b0;
            tx_out_ready <= 1'b0;
            flips <= 0;
            fbit_flips <= 0;
            words <= 0;
        end
        else
        begin
            phase_r <= !phase_r;
            tx_out_ready <= !stall && (!slow || phase_r);
            if (tx_out_valid && tx_out_ready)
            begin
                words <= words + 1;
                flips <= flips + int'(tx_out.data);
                fbit_flips <= fbit_flips + int'(tx_out.data && tx_out.fbit);
            end
        end
    end
endmodule

//--- tb/tb_bci_top.sv
`timescale 1ns/1ps
module tb_bci_top;
    import bci_pkg::*;
    logic        clk = 1'b0;
    logic        nrst = 1'b0;
    bci_hreq_t   hreq = '0;
    logic [7:0]  rdata;
    logic        rx_bit_en = 1'b0;
    logic        rx_sync = 1'b0;
    logic        rx_bit_err = 1'b0;
    logic        counter_clear_ctl = 1'b0;
    logic        ovf_flag_clear = 1'b0;
    logic        bit_total_overflow;
    logic        error_total_overflow;
    logic        per_chan_mode = 1'b0;
    logic [23:0] chan_sel = 24'h00_0000;
    logic        tx_in_valid = 1'b0;
    logic        tx_in_ready;
    bci_txw_t    tx_in = '0;
    logic        tx_out_valid;
    logic        tx_out_ready;
    bci_txw_t    tx_out;
    logic        stall = 1'b0;
    logic        slow = 1'b0;
    int          flips;
    int          fbit_flips;
    int          words;
    int          num_errors = 0;
    int          total_checks = 0;
    int          nb = 4;
    int          ne = 0;
    int          sent = 0;
    int          f0 = 0;
    // 40 MHz clock
    always #12.5 clk = ~clk;
    bci_top u_bci_top (.clk, .nrst, .hreq, .rdata, .rx_bit_en, .rx_sync, .rx_bit_err, .counter_clear_ctl,
        .ovf_flag_clear, .bit_total_overflow, .error_total_overflow, .per_chan_mode, .chan_sel,
        .tx_in_valid, .tx_in_ready, .tx_in, .tx_out_valid, .tx_out_ready, .tx_out);
    bci_line_sink u_bci_line_sink (.clk, .nrst, .stall, .slow, .tx_out_valid, .tx_out, .tx_out_ready,
        .flips, .fbit_flips, .words);
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp)
        begin
            num_errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    // One-cycle strobes, launched at the falling edge
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        hreq = '{1'b0, 1'b1, a, d};
        @(negedge clk);
        hreq.wr = 1'b0;
    endtask
    task automatic pk(input logic [7:0] a);
        @(negedge clk);
        hreq = '{1'b1, 1'b0, a, 8'h00};
        @(negedge clk);
        hreq.rd = 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        pk(a);
        chk($sformatf("reg %h", a), 32'(exp), 32'(rdata));
    endtask
    // Hold a zero bit until the buffer takes it, bounded wait
    task automatic word(input logic f, input int ch);
        int n;
        @(negedge clk);
        tx_in = '{f, ch[4:0], 1'b0};
        tx_in_valid = 1'b1;
        for (n = 0; n < 64 && tx_in_ready !== 1'b1; n++)
            @(negedge clk);
        @(negedge clk);
        tx_in_valid = 1'b0;
        sent++;
    endtask
    // Positions 0..192 of a frame; 0 is the framing bit
    task automatic frame(input int s, input int e);
        for (int i = s; i < e; i++)
            word(i == 0, (i - 1) / 8);
    endtask
    task automatic flips_are(input int n);
        repeat (8) @(negedge clk);
        chk("flips", n, flips - f0);
        f0 = flips;
    endtask
    task automatic complete_run;
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    // Watchdog, about three times the expected run
    initial
    begin
        repeat (10000) @(posedge clk);
        num_errors++;
        complete_run;
    end
    initial
    begin
        repeat (20) @(negedge clk);
        nrst = 1'b1;
        for (int a = BIT_TOTAL_BYTE0; a <= INSERT_REMAIN_HI; a++)
            rd(a[7:0], REG_RESET);
        rd(8'h00, UNMAPPED_RD);
        wr(INSERT_RATE_CTL, 8'hFF);
        rd(INSERT_RATE_CTL, RATE_CTL_WMASK);
        wr(INSERT_RATE_CTL, 8'h00);
        $display("test reset done");
        // Four bits pass during two reads, then every third bit errs
        rx_sync = 1'b1;
        rx_bit_en = 1'b1;
        pk(BIT_TOTAL_BYTE0);
        pk(BIT_TOTAL_BYTE0);
        for (int i = 0; i < 296; i++)
        begin
            rx_bit_err = (i % 3 == 0);
            ne += int'(rx_bit_err);
            nb++;
            @(negedge clk);
        end
        rx_sync = 1'b0;
        rd(BIT_TOTAL_BYTE0, nb[7:0]);
        for (int i = 0; i < 4; i++)
            rd(8'(BIT_TOTAL_BYTE0 + i), nb[8*i +: 8]);
        for (int i = 0; i < 3; i++)
            rd(8'(ERROR_TOTAL_BYTE0 + i), ne[8*i +: 8]);
        counter_clear_ctl = 1'b1;
        rd(BIT_TOTAL_BYTE0, 8'h00);
        rd(ERROR_TOTAL_BYTE0, 8'h00);
        counter_clear_ctl = 1'b0;
        rx_bit_en = 1'b0;
        ovf_flag_clear = 1'b1;
        @(negedge clk);
        ovf_flag_clear = 1'b0;
        chk("overflow", 32'h0, {30'h0, bit_total_overflow, error_total_overflow});
        $display("test counters done");
        // Rates one to three, then code zero with constant set
        for (int k = 1; k <= 4; k++)
        begin
            wr(INSERT_RATE_CTL, 8'h10 | 8'(k % 4));
            frame(0, 193);
            flips_are(k < 4 ? 192 >> (k + 3) : 0);
        end
        wr(INSERT_RATE_CTL, 8'h11);
        frame(0, 97);
        wr(INSERT_RATE_CTL, 8'h10);
        frame(97, 193);
        flips_are(12);
        per_chan_mode = 1'b1;
        chan_sel = 24'h00_00FF;
        slow = 1'b1;
        wr(INSERT_RATE_CTL, 8'h13);
        frame(0, 193);
        flips_are(1);
        per_chan_mode = 1'b0;
        slow = 1'b0;
        // Counted run of two, then a reload needing a fresh rise
        wr(INSERT_RATE_CTL, 8'h01);
        wr(INSERT_COUNT_LOW, 8'h02);
        wr(INSERT_COUNT_HIGH, 8'h00);
        wr(INSERT_RATE_CTL, 8'h81);
        rd(INSERT_REMAIN_LOW, 8'h02);
        frame(0, 193);
        flips_are(2);
        rd(INSERT_REMAIN_LOW, 8'h00);
        wr(INSERT_RATE_CTL, 8'h81);
        rd(INSERT_REMAIN_LOW, 8'h00);
        wr(INSERT_RATE_CTL, 8'h01);
        wr(INSERT_COUNT_LOW, 8'hFF);
        wr(INSERT_COUNT_HIGH, 8'h03);
        wr(INSERT_RATE_CTL, 8'h81);
        rd(INSERT_REMAIN_LOW, 8'hFF);
        rd(INSERT_REMAIN_HI, 8'h03);
        $display("test insertion done");
        // Stalled receiver: two words fill the buffer
        stall = 1'b1;
        word(1'b0, 0);
        word(1'b0, 0);
        chk("in ready", 32'h0, 32'(tx_in_ready));
        stall = 1'b0;
        repeat (8) @(negedge clk);
        chk("words", sent, words);
        chk("framing flips", 32'h0, fbit_flips);
        $display("test buffer done");
        complete_run;
    end
endmodule
